// file: rtl/pms_cfg.svh
// Constants for the printer motion sequencer: velocities, reset values and timing counts
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_CLK_MHZ        250
`define PMS_IDLE_HOME_MS   200
`define PMS_IDLE_HOME_CYC  (`PMS_IDLE_HOME_MS * 1000 * `PMS_CLK_MHZ)
`define PMS_MOTION_TO_US   2000
`define PMS_MOTION_TO_CYC  (`PMS_MOTION_TO_US * `PMS_CLK_MHZ)
`define PMS_STALL_US       1000
`define PMS_STALL_CYC      (`PMS_STALL_US * `PMS_CLK_MHZ)
`define PMS_STEP_US        2000
`define PMS_STEP_CYC       (`PMS_STEP_US * `PMS_CLK_MHZ)
`define PMS_WHEEL_POS      96
`define PMS_BACKOFF_CNT    8
`define PMS_SLOW_ZONE      4
`define PMS_HOLD_CYC       16
`define PMS_FF_STEPS       528
`define PMS_VEL_FAST       8'hC0
`define PMS_VEL_SLOW       8'h20
`define PMS_PHASE_RST      2'h0
`endif

// file: rtl/pms_pkg.sv
// Types shared by the printer motion sequencer modules
package pms_pkg;
  typedef enum logic [3:0] {
    PMS_IDLE, PMS_RST_LEFT, PMS_RST_BACK, PMS_WHEEL_HOME, PMS_CAR_MOVE,
    PMS_WHEEL_MOVE, PMS_INDEX_SEEK, PMS_SETTLE, PMS_STRIKE, PMS_RIBBON, PMS_HALT
  } pms_state_e;
endpackage

// file: rtl/pms_axis_if.sv
// Interface between the sequencer and one axis motion counter
`timescale 1ns/100ps
interface pms_axis_if;
  logic       pulse;    // One-cycle encoder motion pulse
  logic       dir_pos;  // Counting direction
  logic       clear;    // Clear position
  logic [9:0] pos;      // Position count
  modport seq (output pulse, output dir_pos, output clear, input pos);
  modport cnt (input pulse, input dir_pos, input clear, output pos);
endinterface

// file: rtl/pms_axis_counter.sv
// Position counter for one axis, with optional modulo wrap
`timescale 1ns/100ps
module pms_axis_counter #(
  parameter int MODULO = 0
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Sequencer side
  pms_axis_if.cnt  ax
);
  localparam logic [9:0] LAST = 10'(MODULO - 1);
  wire        at_top = (MODULO != 0) && (ax.pos == LAST);
  wire        at_bot = (ax.pos == 10'h000);
  wire [9:0]  next_up = at_top ? 10'h000 : ax.pos + 10'h001;
  wire [9:0]  next_dn = (at_bot && MODULO != 0) ? LAST : ax.pos - 10'h001;
  wire [9:0]  next_pos = ax.clear ? 10'h000 :
                         !ax.pulse ? ax.pos : (ax.dir_pos ? next_up : next_dn);
  logic [9:0] pos_q;
  // Clear beats a simultaneous pulse so index always lands on zero
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) pos_q <= 10'h000;
    else pos_q <= next_pos;
  end
  assign ax.pos = pos_q;
endmodule

// file: rtl/pms_stepper.sv
// Two-phase paper feed stepper sequencer
`include "pms_cfg.svh"
`timescale 1ns/100ps
module pms_stepper #(
  parameter int STEP_CYC = `PMS_STEP_CYC
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Requests
  input  wire logic       step_req_in,
  input  wire logic       fwd_in,
  // Status and phases
  output logic            busy_out,
  output logic            done_out,
  output logic [1:0]      phase_out
);
  logic [1:0]  seq;
  logic [31:0] tmr;
  wire         tmr_done = (tmr == 32'h1);
  wire [1:0]   next_seq = fwd_in ? seq + 2'h1 : seq - 2'h1;
  // Gray order energises phase A, B, not A, not B in turn
  assign phase_out = {seq[1] ^ seq[0], seq[1]};
  assign busy_out  = (tmr != 32'h0);
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      seq      <= `PMS_PHASE_RST;
      tmr      <= 32'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= busy_out && tmr_done;
      if (step_req_in && !busy_out) begin
        seq <= next_seq;
        tmr <= 32'(STEP_CYC);
      end else if (busy_out) begin
        tmr <= tmr - 32'h1;
      end
    end
  end
endmodule

// file: rtl/pms_sequencer.sv
// Printer motion sequencer: homing, counting, fault halt, hammer, ribbon, paper feed
`include "pms_cfg.svh"
`timescale 1ns/100ps
module pms_sequencer #(
  parameter int IDLE_HOME_CYC = `PMS_IDLE_HOME_CYC,
  parameter int MOTION_TO_CYC = `PMS_MOTION_TO_CYC,
  parameter int STALL_CYC     = `PMS_STALL_CYC,
  parameter int STEP_CYC      = `PMS_STEP_CYC
) (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Commands from the interface module
  input  wire logic       restore_in,
  input  wire logic       print_in,
  input  wire logic [6:0] char_pos_in,
  input  wire logic [7:0] hammer_width_in,
  input  wire logic [3:0] ribbon_amt_in,
  input  wire logic       car_move_in,
  input  wire logic [9:0] car_target_in,
  input  wire logic       feed_in,
  input  wire logic       feed_fwd_in,
  input  wire logic       form_feed_in,
  input  wire logic       self_test_in,
  // Panel and switch pins
  input  wire logic       ff_key_in,
  input  wire logic       hammer_dis_in,
  // Encoder pins
  input  wire logic       car_clk_in,
  input  wire logic       wheel_clk_in,
  input  wire logic       wheel_index_in,
  // Servo outputs
  output logic            car_dir_right_out,
  output logic            car_vel_mode_out,
  output logic [7:0]      car_vel_out,
  output logic            wheel_dir_cw_out,
  output logic            wheel_vel_mode_out,
  output logic [7:0]      wheel_vel_out,
  output logic            power_en_out,
  // Mechanism outputs
  output logic            hammer_out,
  output logic            ribbon_step_out,
  output logic [1:0]      feed_phase_out,
  output logic            feed_enable_out,
  // Status
  output logic            halt_out,
  output logic            busy_out,
  output logic            done_out,
  output logic [9:0]      car_pos_out,
  output logic [6:0]      wheel_pos_out
);
  pms_axis_if car_ax();
  pms_axis_if whl_ax();

  // Two-flop synchronisers on all pins
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [2:0] edge_q;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync1  <= 5'h00;
      sync2  <= 5'h00;
      edge_q <= 3'h0;
    end else begin
      sync1  <= {ff_key_in, hammer_dis_in, wheel_index_in, wheel_clk_in, car_clk_in};
      sync2  <= sync1;
      edge_q <= {sync2[2], sync2[1], sync2[0]};
    end
  end
  wire car_pulse  = sync2[0] && !edge_q[0];
  wire whl_pulse  = sync2[1] && !edge_q[1];
  wire index_seen = sync2[2] && !edge_q[2];
  wire hammer_dis = sync2[3];
  wire ff_key     = sync2[4];

  // Local copies of the state names, so the package is never imported
  localparam pms_pkg::pms_state_e PMS_IDLE       = pms_pkg::PMS_IDLE;
  localparam pms_pkg::pms_state_e PMS_RST_LEFT   = pms_pkg::PMS_RST_LEFT;
  localparam pms_pkg::pms_state_e PMS_RST_BACK   = pms_pkg::PMS_RST_BACK;
  localparam pms_pkg::pms_state_e PMS_WHEEL_HOME = pms_pkg::PMS_WHEEL_HOME;
  localparam pms_pkg::pms_state_e PMS_CAR_MOVE   = pms_pkg::PMS_CAR_MOVE;
  localparam pms_pkg::pms_state_e PMS_WHEEL_MOVE = pms_pkg::PMS_WHEEL_MOVE;
  localparam pms_pkg::pms_state_e PMS_INDEX_SEEK = pms_pkg::PMS_INDEX_SEEK;
  localparam pms_pkg::pms_state_e PMS_SETTLE     = pms_pkg::PMS_SETTLE;
  localparam pms_pkg::pms_state_e PMS_STRIKE     = pms_pkg::PMS_STRIKE;
  localparam pms_pkg::pms_state_e PMS_RIBBON     = pms_pkg::PMS_RIBBON;
  localparam pms_pkg::pms_state_e PMS_HALT       = pms_pkg::PMS_HALT;

  pms_pkg::pms_state_e state;
  pms_pkg::pms_state_e next_state;
  logic [31:0] tmr;          // Watchdog / stall timer
  logic [31:0] idle_tmr;
  logic [7:0]  seq_cnt;      // Back-off, hold, strike and ribbon counter
  logic        wheel_homed;
  logic [6:0]  wheel_tgt;
  logic [7:0]  ham_w;
  logic [3:0]  rib_amt;
  logic        rib_phase;
  logic        in_restore;
  logic        in_print;
  logic        ff_key_q;
  logic [9:0]  ff_left;

  // Axis counters: carriage open ended, wheel modulo the wheel size
  pms_axis_counter #(.MODULO(0)) u_car (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .ax       (car_ax.cnt)
  );
  pms_axis_counter #(.MODULO(`PMS_WHEEL_POS)) u_whl (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .ax       (whl_ax.cnt)
  );

  // Carriage counting and homing clear
  assign car_ax.pulse   = car_pulse;
  assign car_ax.dir_pos = car_dir_right_out;
  // Clear on the last back-off pulse itself, so the move is exactly the back-off count
  assign car_ax.clear   = (state == PMS_RST_BACK) && (seq_cnt == 8'h01) && car_pulse;
  // Wheel counting; index always forces zero
  assign whl_ax.pulse   = whl_pulse;
  assign whl_ax.dir_pos = wheel_dir_cw_out;
  assign whl_ax.clear   = index_seen;
  assign car_pos_out    = car_ax.pos;
  assign wheel_pos_out  = whl_ax.pos[6:0];

  // Motion distances and slow zones
  wire [9:0] car_dist  = car_dir_right_out ? car_target_in - car_ax.pos
                                           : car_ax.pos - car_target_in;
  wire       car_at    = (car_ax.pos == car_target_in);
  wire       car_near  = (car_dist <= 10'(`PMS_SLOW_ZONE));
  wire [6:0] whl_dist  = wheel_tgt - whl_ax.pos[6:0];
  wire       whl_at    = (whl_ax.pos[6:0] == wheel_tgt);
  wire       whl_near  = (whl_dist <= 7'(`PMS_SLOW_ZONE));
  wire       moving    = (state == PMS_CAR_MOVE) || (state == PMS_WHEEL_MOVE) ||
                         (state == PMS_WHEEL_HOME) || (state == PMS_INDEX_SEEK);
  // Any pulse of the axis in motion restarts the watchdog
  // Stall detection on the left seek needs carriage pulses, not wheel pulses
  wire       car_phase = (state == PMS_CAR_MOVE) || (state == PMS_RST_LEFT) ||
                         (state == PMS_RST_BACK);
  wire       motion_ev = car_phase ? car_pulse : whl_pulse;
  wire       wd_expire = moving && (tmr >= 32'(MOTION_TO_CYC));
  // Restore seeks index only, so the wheel watchdog is off then
  wire       fault     = wd_expire && !in_restore;
  wire       stalled   = (state == PMS_RST_LEFT) && (tmr >= 32'(STALL_CYC));
  wire       idle_home = (state == PMS_IDLE) && (idle_tmr >= 32'(IDLE_HOME_CYC))
                         && !whl_at;
  // Expected index missing: wheel says zero but no index pulse came with it
  wire       idx_miss  = in_print && (state == PMS_WHEEL_MOVE) && whl_pulse &&
                         (whl_ax.pos[6:0] == 7'(`PMS_WHEEL_POS - 1)) && wheel_dir_cw_out
                         && !sync2[2];
  wire       ff_req    = form_feed_in || (ff_key && !ff_key_q);
  wire       feed_busy;
  wire       feed_done;
  wire       feed_step = (feed_in || (ff_left != 10'h000)) && !halt_out;

  // Next-state decode
  always_comb begin
    next_state = state;
    case (state)
      PMS_IDLE: begin
        if (restore_in) next_state = PMS_RST_LEFT;
        else if (!wheel_homed || idle_home) next_state = PMS_WHEEL_HOME;
        else if (print_in) next_state = whl_at ? PMS_WHEEL_MOVE : PMS_WHEEL_HOME;
        else if (car_move_in && !car_at) next_state = PMS_CAR_MOVE;
      end
      PMS_RST_LEFT:   if (stalled) next_state = PMS_RST_BACK;
      PMS_RST_BACK:   if (car_ax.clear) next_state = PMS_WHEEL_HOME;
      PMS_WHEEL_HOME: if (index_seen) next_state = in_print ? PMS_WHEEL_MOVE : PMS_IDLE;
      PMS_CAR_MOVE:   if (car_at) next_state = PMS_SETTLE;
      PMS_WHEEL_MOVE: begin
        if (idx_miss) next_state = PMS_INDEX_SEEK;
        else if (whl_at) next_state = PMS_SETTLE;
      end
      PMS_INDEX_SEEK: if (index_seen) next_state = PMS_WHEEL_MOVE;
      PMS_SETTLE: begin
        if (seq_cnt == 8'(`PMS_HOLD_CYC)) next_state = in_print ? PMS_STRIKE : PMS_IDLE;
      end
      PMS_STRIKE:     if (seq_cnt == ham_w) next_state = PMS_RIBBON;
      PMS_RIBBON:     if (seq_cnt == {3'h0, rib_amt, 1'b0}) next_state = PMS_IDLE;
      PMS_HALT:       if (restore_in) next_state = PMS_RST_LEFT;
      default:        next_state = PMS_HALT;
    endcase
    if (fault) next_state = PMS_HALT;
  end

  // Main state, mode flags and latched operands
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state       <= PMS_IDLE;
      wheel_homed <= 1'b0;
      in_restore  <= 1'b0;
      in_print    <= 1'b0;
      wheel_tgt   <= 7'h00;
      ham_w       <= 8'h00;
      rib_amt     <= 4'h0;
      ff_key_q    <= 1'b0;
    end else begin
      state    <= next_state;
      ff_key_q <= ff_key;
      if (index_seen && state == PMS_WHEEL_HOME) wheel_homed <= 1'b1;
      if (next_state == PMS_RST_LEFT) in_restore <= 1'b1;
      else if (next_state == PMS_IDLE || next_state == PMS_HALT) in_restore <= 1'b0;
      if (state == PMS_IDLE && print_in && !restore_in && wheel_homed && !idle_home) begin
        in_print  <= 1'b1;
        wheel_tgt <= char_pos_in;
        ham_w     <= hammer_width_in;
        rib_amt   <= ribbon_amt_in;
      end else if (next_state == PMS_IDLE || next_state == PMS_HALT) begin
        in_print  <= 1'b0;
        wheel_tgt <= 7'h00;
      end
    end
  end

  // Watchdog, idle timer and sequence counter
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tmr      <= 32'h0;
      idle_tmr <= 32'h0;
      seq_cnt  <= 8'h00;
    end else begin
      if (next_state != state || motion_ev) tmr <= 32'h0;
      else tmr <= tmr + 32'h1;
      if (state != PMS_IDLE || print_in) idle_tmr <= 32'h0;
      else if (idle_tmr < 32'(IDLE_HOME_CYC)) idle_tmr <= idle_tmr + 32'h1;
      if (next_state != state) seq_cnt <= (next_state == PMS_RST_BACK) ?
                                          8'(`PMS_BACKOFF_CNT) : 8'h00;
      else if (state == PMS_RST_BACK) seq_cnt <= car_pulse ? seq_cnt - 8'h01 : seq_cnt;
      else seq_cnt <= seq_cnt + 8'h01;
    end
  end

  // Form feed step counter, 528 steps per request
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) ff_left <= 10'h000;
    else if (ff_req) ff_left <= 10'(`PMS_FF_STEPS);
    else if (feed_step && !feed_busy && ff_left != 10'h000) ff_left <= ff_left - 10'h001;
  end

  pms_stepper #(.STEP_CYC(STEP_CYC)) u_feed (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .step_req_in (feed_step),
    .fwd_in      (feed_fwd_in || (ff_left != 10'h000)),
    .busy_out    (feed_busy),
    .done_out    (feed_done),
    .phase_out   (feed_phase_out)
  );
  assign feed_enable_out = 1'b1;

  // Servo commands; position mode holds the axis whenever it is not moving
  assign halt_out           = (state == PMS_HALT);
  assign power_en_out       = !halt_out;
  assign car_dir_right_out  = (state == PMS_RST_BACK) ||
                              ((state == PMS_CAR_MOVE) && (car_target_in > car_ax.pos));
  assign car_vel_mode_out   = (state == PMS_RST_LEFT) || (state == PMS_RST_BACK) ||
                              (state == PMS_CAR_MOVE);
  assign car_vel_out        = !car_vel_mode_out ? 8'h00 :
                              ((state != PMS_CAR_MOVE) || car_near) ? `PMS_VEL_SLOW
                                                                    : `PMS_VEL_FAST;
  assign wheel_dir_cw_out   = 1'b1;
  assign wheel_vel_mode_out = (state == PMS_WHEEL_HOME) || (state == PMS_WHEEL_MOVE) ||
                              (state == PMS_INDEX_SEEK);
  assign wheel_vel_out      = !wheel_vel_mode_out ? 8'h00 :
                              ((state == PMS_WHEEL_MOVE) && !whl_near) ? `PMS_VEL_FAST
                                                                       : `PMS_VEL_SLOW;
  // Strike only after settle; disable pin masks the pulse but not the sequence
  assign hammer_out         = (state == PMS_STRIKE) && !hammer_dis && (seq_cnt < ham_w);
  assign ribbon_step_out    = (state == PMS_RIBBON) && seq_cnt[0];
  assign busy_out           = (state != PMS_IDLE) && !halt_out;
  assign done_out           = (state == PMS_RIBBON) && (next_state == PMS_IDLE);

  // Checks
  a_halt_drives_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    halt_out |-> !power_en_out && !car_vel_mode_out && !wheel_vel_mode_out)
    else $error("drives on while halted");
  a_fault_to_halt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    fault |=> halt_out) else $error("fault did not halt");
  a_halt_sticks: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    halt_out && !restore_in |=> halt_out) else $error("halt left without restore");
  a_restore_no_fault: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    in_restore |=> !halt_out) else $error("fault during restore");
  a_homing_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    car_ax.clear |=> car_pos_out == 10'h000) else $error("carriage not zeroed");
  a_index_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    index_seen |=> wheel_pos_out == 7'h00) else $error("index did not zero wheel");
  a_hammer_at_rest: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    hammer_out |-> !car_vel_mode_out && !wheel_vel_mode_out) else $error("strike in motion");
  a_hammer_masked: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    hammer_dis |-> !hammer_out) else $error("strike while disabled");
  a_feed_enabled: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    feed_enable_out) else $error("feed disabled");
  a_left_seek: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == PMS_RST_LEFT |-> !car_dir_right_out && car_vel_mode_out)
    else $error("restore not seeking left");
  a_backoff_right: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == PMS_RST_BACK |-> car_dir_right_out && car_vel_mode_out)
    else $error("back-off not moving right");
  a_idle_homes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    idle_home && !restore_in && !fault |=> state == PMS_WHEEL_HOME)
    else $error("idle wheel not homed");
  a_index_resume: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == PMS_INDEX_SEEK && index_seen && !fault |=> state == PMS_WHEEL_MOVE)
    else $error("print not resumed after index");
  a_settle_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == PMS_SETTLE |-> !car_vel_mode_out && !wheel_vel_mode_out)
    else $error("axis not held at settle");
  a_feed_one_phase: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (feed_phase_out ^ $past(feed_phase_out)) != 2'h3)
    else $error("both feed phases switched at once");
  a_ribbon_at_rest: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ribbon_step_out |-> !car_vel_mode_out && !wheel_vel_mode_out)
    else $error("ribbon stepped in motion");
endmodule

// file: testbench/pms_host_model.sv
// Interface module model: issues print, move, restore and feed requests
`timescale 1ns/100ps
module pms_host_model (
  // Clock and status
  input  wire logic       clock_in,
  input  wire logic       busy_in,
  input  wire logic       halt_in,
  // Commands
  output logic            restore_out,
  output logic            print_out,
  output logic [6:0]      char_pos_out,
  output logic [7:0]      hammer_width_out,
  output logic [3:0]      ribbon_amt_out,
  output logic            car_move_out,
  output logic [9:0]      car_target_out,
  output logic            feed_out,
  output logic            feed_fwd_out,
  output logic            form_feed_out
);
  // Quiet bus at time zero
  initial begin
    {restore_out, print_out, car_move_out, feed_out, feed_fwd_out, form_feed_out} = 6'h00;
    {char_pos_out, hammer_width_out, ribbon_amt_out, car_target_out} = 29'h0;
  end

  // Hold a request until the sequencer shows it busy and out of halt, giving up after 40 cycles
  task automatic wait_taken(output bit ok);
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clock_in);
      if (busy_in === 1'b1 && halt_in !== 1'b1) ok = 1;
    end
  endtask

  task automatic do_restore(output bit ok);
    @(posedge clock_in);
    restore_out <= 1'b1;
    wait_taken(ok);
    restore_out <= 1'b0;
  endtask

  task automatic do_print(input logic [6:0] c, input logic [7:0] w, input logic [3:0] r,
                          output bit ok);
    @(posedge clock_in);
    {char_pos_out, hammer_width_out, ribbon_amt_out} <= {c, w, r};
    print_out <= 1'b1;
    wait_taken(ok);
    print_out <= 1'b0;
  endtask

  // Target is set with the request and kept; the request is released once taken or after 40 cycles
  task automatic do_move(input logic [9:0] t, output bit ok);
    @(posedge clock_in);
    car_target_out <= t;
    car_move_out <= 1'b1;
    wait_taken(ok);
    car_move_out <= 1'b0;
  endtask

  // Single paper step, a one-cycle request
  task automatic do_feed(input logic fwd);
    @(posedge clock_in);
    feed_fwd_out <= fwd;
    feed_out <= 1'b1;
    @(posedge clock_in);
    feed_out <= 1'b0;
  endtask

  // Host form feed pulse
  task automatic do_form_feed();
    @(posedge clock_in);
    form_feed_out <= 1'b1;
    @(posedge clock_in);
    form_feed_out <= 1'b0;
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the printer motion sequencer with a mechanism model
`timescale 1ns/100ps
module tb_top;
  logic clock_in, rst_n_in, ff_key_in, hammer_dis_in, car_clk_in, wheel_clk_in, wheel_index_in;
  logic restore_in, print_in, car_move_in, feed_in, feed_fwd_in, form_feed_in;
  logic [6:0] char_pos_in, wheel_pos_out;
  logic [7:0] hammer_width_in, car_vel_out, wheel_vel_out;
  logic [3:0] ribbon_amt_in;
  logic [9:0] car_target_in, car_pos_out;
  logic car_dir_right_out, car_vel_mode_out, wheel_dir_cw_out, wheel_vel_mode_out, power_en_out;
  logic hammer_out, ribbon_step_out, feed_enable_out, halt_out, busy_out, done_out;
  logic [1:0] feed_phase_out, last_phase, last_rib;
  logic [2:0] cdiv;
  int   fail_count, checks, mcar, mwhl, ham_cyc, rib_rises, feed_chg, bad_strike;
  logic car_en, whl_en;
  bit   ok, seen;

  pms_sequencer #(.IDLE_HOME_CYC(200), .MOTION_TO_CYC(50), .STALL_CYC(20), .STEP_CYC(4)) DUT (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .restore_in(restore_in), .print_in(print_in),
    .char_pos_in(char_pos_in), .hammer_width_in(hammer_width_in),
    .ribbon_amt_in(ribbon_amt_in), .car_move_in(car_move_in), .car_target_in(car_target_in),
    .feed_in(feed_in), .feed_fwd_in(feed_fwd_in), .form_feed_in(form_feed_in),
    .self_test_in(1'b0), .ff_key_in(ff_key_in), .hammer_dis_in(hammer_dis_in),
    .car_clk_in(car_clk_in), .wheel_clk_in(wheel_clk_in), .wheel_index_in(wheel_index_in),
    .car_dir_right_out(car_dir_right_out), .car_vel_mode_out(car_vel_mode_out),
    .car_vel_out(car_vel_out), .wheel_dir_cw_out(wheel_dir_cw_out),
    .wheel_vel_mode_out(wheel_vel_mode_out), .wheel_vel_out(wheel_vel_out),
    .power_en_out(power_en_out), .hammer_out(hammer_out), .ribbon_step_out(ribbon_step_out),
    .feed_phase_out(feed_phase_out), .feed_enable_out(feed_enable_out), .halt_out(halt_out),
    .busy_out(busy_out), .done_out(done_out), .car_pos_out(car_pos_out),
    .wheel_pos_out(wheel_pos_out));

  pms_host_model host (
    .clock_in(clock_in), .busy_in(busy_out), .halt_in(halt_out), .restore_out(restore_in),
    .print_out(print_in), .char_pos_out(char_pos_in), .hammer_width_out(hammer_width_in),
    .ribbon_amt_out(ribbon_amt_in), .car_move_out(car_move_in),
    .car_target_out(car_target_in), .feed_out(feed_in), .feed_fwd_out(feed_fwd_in),
    .form_feed_out(form_feed_in));

  // Clock at 4 ns
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // Mechanism: encoder pulses every 8 cycles, so none is in flight when an axis stops
  always @(posedge clock_in) begin
    automatic bit cmv = car_vel_mode_out === 1'b1 && car_en && (car_dir_right_out === 1'b1 || mcar > 0);
    automatic bit wmv = wheel_vel_mode_out === 1'b1 && whl_en;
    cdiv <= cdiv + 3'h1;
    car_clk_in <= cmv && cdiv < 3'h2;
    if (cmv && cdiv < 3'h2 && !car_clk_in) mcar <= car_dir_right_out ? mcar + 1 : mcar - 1;
    wheel_clk_in <= wmv && cdiv < 3'h2;
    wheel_index_in <= wmv && cdiv < 3'h2 && (wheel_clk_in ? mwhl == 0 : mwhl == 95);
    if (wmv && cdiv < 3'h2 && !wheel_clk_in) mwhl <= (mwhl == 95) ? 0 : mwhl + 1;
    // Output watchers for strike, ribbon and paper feed
    if (hammer_out === 1'b1) ham_cyc <= ham_cyc + 1;
    if (hammer_out === 1'b1 && (car_vel_mode_out !== 1'b0 || wheel_vel_mode_out !== 1'b0))
      bad_strike <= bad_strike + 1;
    last_rib <= {last_rib[0], ribbon_step_out};
    if (ribbon_step_out === 1'b1 && last_rib[0] === 1'b0) rib_rises <= rib_rises + 1;
    last_phase <= feed_phase_out;
    if (feed_phase_out !== last_phase) feed_chg <= feed_chg + 1;
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Bounded wait for a quiet sequencer with both axes holding
  task automatic wait_idle(input int bound);
    seen = 0;
    for (int i = 0; i < bound && !seen; i++) begin
      @(posedge clock_in);
      #1 seen = busy_out === 1'b0 && car_vel_mode_out === 1'b0 && wheel_vel_mode_out === 1'b0;
    end
    if (!seen) begin
      fail_count++;
      $display("BAD idle wait expected 1 seen 0");
      tally_and_finish();
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // Print one character and compare strike width, ribbon steps and final slot
  task automatic print_one(input logic [6:0] c, input logic [7:0] w, input logic [3:0] r);
    seen = 0;
    @(posedge clock_in);
    {ham_cyc, rib_rises, bad_strike} <= '0;
    host.do_print(c, w, r, ok);
    for (int i = 0; i < 3000 && !seen; i++) begin
      @(posedge clock_in);
      #1 seen = done_out === 1'b1;
    end
    cycles(2);
    check("print done", 1, seen);
    check("hammer cycles", hammer_dis_in ? 0 : w, ham_cyc);
    check("strike at rest", 0, bad_strike);
    check("ribbon steps", r, rib_rises);
    check("wheel slot", c, wheel_pos_out);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    {rst_n_in, ff_key_in, hammer_dis_in, car_clk_in, wheel_clk_in, wheel_index_in} = 6'h00;
    {fail_count, checks, ham_cyc, rib_rises, feed_chg, bad_strike} = '0;
    {cdiv, last_phase, last_rib} = 7'h00;
    car_en = 1'b1;
    whl_en = 1'b1;
    mcar = 30;
    mwhl = 37;
    cycles(4);
    rst_n_in <= 1'b1;
    wait_idle(2000);
    check("feed enable", 1, feed_enable_out);
    check("power-up home", 0, wheel_pos_out);
    $display("test power_up done");
    // Restore: left into the frame, then back off and zero the count
    host.do_restore(ok);
    cycles(4);
    check("restore left", 0, car_dir_right_out);
    check("restore vel", 1, car_vel_mode_out);
    check("restore speed", 8'h20, car_vel_out);
    wait_idle(2000);
    check("backoff travel", 8, mcar);
    check("restore zero", 0, car_pos_out);
    check("restore wheel", 0, wheel_pos_out);
    $display("test restore done");
    host.do_move(10'h014, ok);
    wait_idle(2000);
    check("move count", 10'h014, car_pos_out);
    check("move travel", 28, mcar);
    $display("test move done");
    print_one(7'h05, 8'h06, 4'h3);
    cycles(1100);
    check("idle home", 0, wheel_pos_out);
    print_one(7'h5F, 8'h01, 4'h1);
    hammer_dis_in <= 1'b1;
    print_one(7'h0A, 8'h09, 4'h2);
    hammer_dis_in <= 1'b0;
    $display("test print done");
    // Paper feed: single steps each way, then form feed from host and from key
    for (int d = 0; d < 2; d++) begin
      feed_chg <= 0;
      host.do_feed(d[0]);
      cycles(40);
      check("single step", 1, feed_chg);
    end
    for (int k = 0; k < 2; k++) begin
      feed_chg <= 0;
      if (k == 0) host.do_form_feed();
      else begin
        ff_key_in <= 1'b1;
        cycles(8);
        ff_key_in <= 1'b0;
      end
      cycles(3000);
      check("form feed steps", 528, feed_chg);
    end
    $display("test feed done");
    // Carriage without encoder pulses halts and stays halted
    car_en = 1'b0;
    host.do_move(10'h028, ok);
    cycles(120);
    check("car halt", 1, halt_out);
    check("power off", 0, power_en_out);
    host.do_print(7'h01, 8'h01, 4'h1, ok);
    check("halt refuses", 0, ok);
    check("halt holds", 1, halt_out);
    car_en = 1'b1;
    host.do_restore(ok);
    wait_idle(2000);
    check("halt cleared", 0, halt_out);
    check("rezero", 0, car_pos_out);
    $display("test car_fault done");
    // Printwheel drive off during print halts
    whl_en = 1'b0;
    host.do_print(7'h30, 8'h01, 4'h1, ok);
    cycles(150);
    check("wheel halt", 1, halt_out);
    whl_en = 1'b1;
    host.do_restore(ok);
    wait_idle(2000);
    check("wheel cleared", 0, halt_out);
    $display("test wheel_fault done");
    tally_and_finish();
  end
endmodule
